// >>> verilog/fcs_pkg.sv
// Package for the flash command and status block: register map,
// command codes, status bit layout and the structs that carry grouped
// signals. Assumes a 32-bit register port with byte addresses.
package fcs_pkg;

   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;

   localparam logic [31:0] MODE_RESET = 32'h0400_0000;
   localparam logic [31:0] MODE_WMASK = 32'h0501_0f01;
   localparam int MODE_IRQ_EN_BIT = 0;
   localparam int MODE_WS_LSB = 8;
   localparam int WS_W = 4;

   localparam int CODE_LSB = 0;
   localparam int ARG_LSB = 8;
   localparam int KEY_LSB = 24;
   localparam int CODE_W = 8;
   localparam int ARG_W = 16;
   localparam logic [7:0] KEY_VALUE = 8'h5a;

   localparam int ST_READY_BIT = 0;
   localparam int ST_CMDERR_BIT = 1;
   localparam int ST_LOCKERR_BIT = 2;
   localparam int ST_VERIFY_BIT = 3;
   localparam int ST_ECC_LSB = 16;

   localparam logic [7:0] CMD_FETCH_INFO = 8'h00;
   localparam logic [7:0] CMD_PROG_PAGE = 8'h01;
   localparam logic [7:0] CMD_PROG_LOCK = 8'h02;
   localparam logic [7:0] CMD_CLR_PROG = 8'h03;
   localparam logic [7:0] CMD_CLR_PROG_LOCK = 8'h04;
   localparam logic [7:0] CMD_WIPE_ALL = 8'h05;
   localparam logic [7:0] CMD_HOLE = 8'h06;
   localparam logic [7:0] CMD_ERASE_GROUP = 8'h07;
   localparam logic [7:0] CMD_LOCK = 8'h08;
   localparam logic [7:0] CMD_UNLOCK = 8'h09;
   localparam logic [7:0] CMD_QUERY_LOCK = 8'h0a;
   localparam logic [7:0] CMD_SET_BOOT = 8'h0b;
   localparam logic [7:0] CMD_CLR_BOOT = 8'h0c;
   localparam logic [7:0] CMD_QUERY_BOOT = 8'h0d;
   localparam logic [7:0] CMD_BEGIN_ID = 8'h0e;
   localparam logic [7:0] CMD_END_ID = 8'h0f;
   localparam logic [7:0] CMD_QUERY_CALIB = 8'h10;
   localparam logic [7:0] CMD_ERASE_SECTOR = 8'h11;
   localparam logic [7:0] CMD_PROG_SIG = 8'h12;
   localparam logic [7:0] CMD_WIPE_SIG = 8'h13;
   localparam logic [7:0] CMD_BEGIN_SIG = 8'h14;
   localparam logic [7:0] CMD_END_SIG = 8'h15;

   localparam int GROUP_BASE_LOG2 = 2;
   localparam logic [15:0] GROUP_BASE = 16'h0004;

   typedef struct packed {
      logic [7:0] code;
      logic [15:0] page;
      logic [15:0] count;
   } fcs_array_req_t;

   typedef struct packed {
      logic multi_hi;
      logic single_hi;
      logic multi_lo;
      logic single_lo;
   } fcs_ecc_evt_t;

endpackage

// >>> verilog/fcs_lock_bits.sv
// Region lock bit store for the flash command block.
// Assumes set and clear come from the sequencer on the same clock.
`timescale 1ns/100ps
module fcs_lock_bits #(
   parameter int NREG = 64,
   parameter int IDX_W = 6
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_set,
   input wire logic i_clr,
   input wire logic [IDX_W-1:0] i_idx,
   output logic [NREG-1:0] o_bits
);

   logic [NREG-1:0] bits_ff;

   // Lock state is volatile here; a real array would reload it at boot.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bits_ff <= '0;
      end else if (i_set) begin
         bits_ff[i_idx] <= 1'b1;
      end else if (i_clr) begin
         bits_ff[i_idx] <= 1'b0;
      end
   end

   assign o_bits = bits_ff;

endmodule

// >>> verilog/fcs_ecc_flags.sv
// Sticky ECC error flags for the two halves of the read data word.
// Assumes event pulses arrive on the core clock from the read path.
`timescale 1ns/100ps
module fcs_ecc_flags (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire fcs_pkg::fcs_ecc_evt_t i_evt,
   input wire logic i_clear,
   output fcs_pkg::fcs_ecc_evt_t o_flags
);
   import fcs_pkg::*;

   fcs_ecc_evt_t flags_ff;

   // An error seen in the same cycle as the status read survives it.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= i_evt | (i_clear ? '0 : flags_ff);
      end
   end

   assign o_flags = flags_ff;

endmodule

// >>> verilog/fcs_core.sv
// Flash command sequencer: key-checked command word, status word,
// mode word and result word on a plain register port.
// Assumes the flash array and read path run on the core clock.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps

// Operation
// - Codes 01 to 04 decode the four page program forms.
// - Codes 08, 09, 0A set, clear, read a region lock bit.
// - Codes 0B, 0C, 0D set, clear, read a boot option bit.
// - Code 0E enters, 0F leaves identifier read mode.
// - Codes 12, 13 program, wipe signature; 14, 15 start, stop reading.
// - Erase group: argument bits 1:0 pick four to thirty-two pages.
// - Only key 5A lets a command write take effect.
// - Status bit 0 is one when idle, zero while busy.
// - Interrupt asserts while ready and ready interrupt enabled.
// - Bad code or key sets bit 1; read or command write clears.
// - Locked-region hit sets bit 2; read or command write clears.
// - Verify failure sets bit 3; next programming start clears it.
// - Bits 16 and 18 hold single ECC errors until status read.
// - Bits 17 and 19 hold multiple ECC errors until status read.
// - Query results appear in result word, one word per read.
// - Mode bit 0 enables the ready interrupt.
module fcs_core #(
   parameter int NREG = 64,
   parameter int REG_W = 6,
   parameter int PAGE_REG_LOG2 = 7,
   parameter int NBOOT = 8,
   parameter logic [31:0] INFO_ID = 32'h0000_0a5c,
   parameter logic [31:0] INFO_SIZE = 32'h0010_0000,
   parameter logic [31:0] INFO_PAGE = 32'h0000_0200,
   parameter logic [31:0] CALIB_BITS = 32'h0000_0000
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output fcs_pkg::fcs_array_req_t o_array_req,
   output logic o_array_start,
   input wire logic i_array_done,
   input wire logic i_array_verify_fail,
   input wire fcs_pkg::fcs_ecc_evt_t i_ecc,
   output logic o_id_mode,
   output logic o_sig_mode,
   output logic [NBOOT-1:0] o_boot_bits,
   output logic [fcs_pkg::WS_W-1:0] o_wait_states
);
   import fcs_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_CHECK, S_WAIT} fcs_state_t;

   localparam int LOCK_WORDS = (NREG + 31) / 32;
   localparam int INFO_WORDS = 4;

   fcs_state_t state_ff;
   logic [31:0] mode_ff;
   logic [7:0] code_ff;
   logic [ARG_W-1:0] arg_ff;
   logic cmd_err_ff;
   logic lock_err_ff;
   logic verify_err_ff;
   logic id_mode_ff;
   logic sig_mode_ff;
   logic [NBOOT-1:0] boot_ff;
   logic [7:0] res_kind_ff;
   logic [3:0] res_idx_ff;
   logic [31:0] rdata_ff;
   logic irq_ff;
   logic start_ff;
   fcs_array_req_t req_ff;
   logic [WS_W-1:0] ws_ff;

   logic [NREG-1:0] lock_bits;
   fcs_ecc_evt_t ecc_flags;

   logic wr_mode;
   logic wr_cmd;
   logic rd_status;
   logic rd_result;
   logic key_ok;
   logic [7:0] wr_code;
   logic accept;
   logic bad_cmd;
   logic idle;
   logic [15:0] grp_count;
   logic [15:0] grp_start;
   logic [15:0] tgt_first;
   logic [15:0] tgt_last;
   logic tgt_locked;
   logic is_array;
   logic lock_set;
   logic lock_clr;
   logic [REG_W-1:0] lock_idx;
   logic lock_err_set;
   logic [31:0] status_word;
   logic [31:0] nxt_rdata;

   function automatic logic code_valid(input logic [7:0] c);
      return (c <= CMD_END_SIG) && (c != CMD_HOLE);
   endfunction

   function automatic logic code_array(input logic [7:0] c);
      return (c >= CMD_PROG_PAGE && c <= CMD_WIPE_ALL) ||
             c == CMD_ERASE_GROUP || c == CMD_ERASE_SECTOR ||
             c == CMD_PROG_SIG || c == CMD_WIPE_SIG;
   endfunction

   function automatic logic [REG_W-1:0] region_of(input logic [15:0] p);
      logic [15:0] r;
      r = p >> PAGE_REG_LOG2;
      return r[REG_W-1:0];
   endfunction

   assign idle = (state_ff == S_IDLE);
   assign wr_mode = i_wr && i_addr == ADDR_MODE;
   assign wr_cmd = i_wr && i_addr == ADDR_CMD;
   assign rd_status = i_rd && i_addr == ADDR_STATUS;
   assign rd_result = i_rd && i_addr == ADDR_RESULT;
   assign key_ok = i_wdata[KEY_LSB +: 8] == KEY_VALUE;
   assign wr_code = i_wdata[CODE_LSB +: CODE_W];
   // A command written while busy is dropped; software must poll ready.
   assign accept = wr_cmd && key_ok && code_valid(wr_code) && idle;
   assign bad_cmd = wr_cmd && !(key_ok && code_valid(wr_code));

   // The group base is four pages; each count step doubles it.
   assign grp_count = GROUP_BASE << arg_ff[1:0];
   assign grp_start = {arg_ff[ARG_W-1:GROUP_BASE_LOG2],
                       {GROUP_BASE_LOG2{1'b0}}};

   always_comb begin
      tgt_first = arg_ff;
      tgt_last = arg_ff;
      if (code_ff == CMD_ERASE_GROUP) begin
         tgt_first = grp_start;
         tgt_last = 16'(grp_start + grp_count - 16'h0001);
      end
   end

   assign is_array = code_array(code_ff);

   always_comb begin
      case (code_ff)
         CMD_WIPE_ALL: tgt_locked = |lock_bits;
         CMD_PROG_SIG, CMD_WIPE_SIG: tgt_locked = 1'b0;
         default: tgt_locked = lock_bits[region_of(tgt_first)] ||
                               lock_bits[region_of(tgt_last)];
      endcase
   end

   assign lock_err_set = state_ff == S_CHECK && is_array && tgt_locked;

   always_comb begin
      lock_set = 1'b0;
      lock_clr = 1'b0;
      lock_idx = region_of(arg_ff);
      if (state_ff == S_CHECK) begin
         lock_set = code_ff == CMD_LOCK;
         lock_clr = code_ff == CMD_UNLOCK;
      end else if (state_ff == S_WAIT && i_array_done) begin
         lock_set = code_ff == CMD_PROG_LOCK ||
                    code_ff == CMD_CLR_PROG_LOCK;
      end
   end

   fcs_lock_bits #(
      .NREG(NREG),
      .IDX_W(REG_W)
   ) u_lock (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_set(lock_set),
      .i_clr(lock_clr),
      .i_idx(lock_idx),
      .o_bits(lock_bits)
   );

   fcs_ecc_flags u_ecc (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_evt(i_ecc),
      .i_clear(rd_status),
      .o_flags(ecc_flags)
   );

   // Sequencer.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_ff <= S_IDLE;
         code_ff <= 8'h00;
         arg_ff <= 16'h0000;
      end else begin
         case (state_ff)
            S_IDLE: begin
               if (accept) begin
                  state_ff <= S_CHECK;
                  code_ff <= wr_code;
                  arg_ff <= i_wdata[ARG_LSB +: ARG_W];
               end
            end
            S_CHECK: begin
               state_ff <= (is_array && !tgt_locked) ? S_WAIT : S_IDLE;
            end
            S_WAIT: begin
               if (i_array_done) begin
                  state_ff <= S_IDLE;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // Array request, one pulse per unlocked program or erase.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         start_ff <= 1'b0;
         req_ff <= '0;
      end else begin
         start_ff <= state_ff == S_CHECK && is_array && !tgt_locked;
         if (state_ff == S_CHECK) begin
            req_ff.code <= code_ff;
            req_ff.page <= tgt_first;
            req_ff.count <= (code_ff == CMD_ERASE_GROUP) ?
                            grp_count : 16'h0001;
         end
      end
   end

   // Error flags; a new error in the clearing cycle wins.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmd_err_ff <= 1'b0;
         lock_err_ff <= 1'b0;
         verify_err_ff <= 1'b0;
      end else begin
         if (bad_cmd) begin
            cmd_err_ff <= 1'b1;
         end else if (rd_status || wr_cmd) begin
            cmd_err_ff <= 1'b0;
         end
         if (lock_err_set) begin
            lock_err_ff <= 1'b1;
         end else if (rd_status || wr_cmd) begin
            lock_err_ff <= 1'b0;
         end
         if (state_ff == S_WAIT && i_array_done && i_array_verify_fail) begin
            verify_err_ff <= 1'b1;
         end else if (start_ff) begin
            verify_err_ff <= 1'b0;
         end
      end
   end

   // Boot options and read modes.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         boot_ff <= '0;
         id_mode_ff <= 1'b0;
         sig_mode_ff <= 1'b0;
      end else if (state_ff == S_CHECK) begin
         // An index beyond the implemented bits is silently ignored.
         if (arg_ff < 16'(NBOOT)) begin
            if (code_ff == CMD_SET_BOOT) begin
               boot_ff[arg_ff[$clog2(NBOOT)-1:0]] <= 1'b1;
            end else if (code_ff == CMD_CLR_BOOT) begin
               boot_ff[arg_ff[$clog2(NBOOT)-1:0]] <= 1'b0;
            end
         end
         if (code_ff == CMD_BEGIN_ID) begin
            id_mode_ff <= 1'b1;
         end else if (code_ff == CMD_END_ID) begin
            id_mode_ff <= 1'b0;
         end
         if (code_ff == CMD_BEGIN_SIG) begin
            sig_mode_ff <= 1'b1;
         end else if (code_ff == CMD_END_SIG) begin
            sig_mode_ff <= 1'b0;
         end
      end
   end

   // Result selection: a query restarts the word index at zero.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         res_kind_ff <= CMD_HOLE;
         res_idx_ff <= 4'h0;
      end else if (state_ff == S_CHECK && (code_ff == CMD_FETCH_INFO ||
               code_ff == CMD_QUERY_LOCK || code_ff == CMD_QUERY_BOOT ||
               code_ff == CMD_QUERY_CALIB)) begin
         res_kind_ff <= code_ff;
         res_idx_ff <= 4'h0;
      end else if (rd_result && res_idx_ff != 4'hf) begin
         res_idx_ff <= res_idx_ff + 4'h1;
      end
   end

   function automatic logic [31:0] result_word(input logic [7:0] k,
                                               input logic [3:0] i);
      logic [NREG+31:0] padded;
      padded = {32'h0000_0000, lock_bits};
      result_word = 32'h0000_0000;
      case (k)
         CMD_FETCH_INFO: begin
            case (i)
               4'h0: result_word = INFO_ID;
               4'h1: result_word = INFO_SIZE;
               4'h2: result_word = INFO_PAGE;
               4'h3: result_word = 32'(NREG);
               default: result_word = 32'h0000_0000;
            endcase
         end
         CMD_QUERY_LOCK: begin
            if (int'(i) < LOCK_WORDS) begin
               result_word = padded[32*i +: 32];
            end
         end
         CMD_QUERY_BOOT: begin
            if (i == 4'h0) begin
               result_word = 32'(boot_ff);
            end
         end
         CMD_QUERY_CALIB: begin
            if (i == 4'h0) begin
               result_word = CALIB_BITS;
            end
         end
         default: result_word = 32'h0000_0000;
      endcase
   endfunction

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_READY_BIT] = idle;
      status_word[ST_CMDERR_BIT] = cmd_err_ff;
      status_word[ST_LOCKERR_BIT] = lock_err_ff;
      status_word[ST_VERIFY_BIT] = verify_err_ff;
      status_word[ST_ECC_LSB +: 4] = ecc_flags;
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            ADDR_MODE: nxt_rdata = mode_ff;
            ADDR_STATUS: nxt_rdata = status_word;
            ADDR_RESULT: nxt_rdata = result_word(res_kind_ff, res_idx_ff);
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Register port, mode word and interrupt.
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_ff <= MODE_RESET;
         rdata_ff <= 32'h0000_0000;
         irq_ff <= 1'b0;
         ws_ff <= '0;
      end else begin
         if (wr_mode) begin
            mode_ff <= i_wdata & MODE_WMASK;
         end
         rdata_ff <= nxt_rdata;
         ws_ff <= mode_ff[MODE_WS_LSB +: WS_W];
         irq_ff <= idle && mode_ff[MODE_IRQ_EN_BIT];
      end
   end

   assign o_rdata = rdata_ff;
   assign o_irq = irq_ff;
   assign o_array_start = start_ff;
   assign o_array_req = req_ff;
   assign o_id_mode = id_mode_ff;
   assign o_sig_mode = sig_mode_ff;
   assign o_boot_bits = boot_ff;
   assign o_wait_states = ws_ff;

   bad_key_a: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      wr_cmd && !key_ok |=> cmd_err_ff && $stable(state_ff))
      else $error("bad key did not flag or changed state");
   ready_busy_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      accept |=> !status_word[ST_READY_BIT])
      else $error("ready bit not cleared after accepted command");
   irq_level_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      ##1 o_irq == $past(idle && mode_ff[MODE_IRQ_EN_BIT]))
      else $error("interrupt does not follow ready and enable");
   bad_code_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      wr_cmd && key_ok && !code_valid(wr_code) |=>
         cmd_err_ff && idle ##1 !o_array_start)
      else $error("unassigned code not flagged or started work");
   lock_err_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      lock_err_set |=> lock_err_ff && !o_array_start)
      else $error("locked region hit not flagged or array started");
   verify_clr_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      o_array_start |=> !verify_err_ff)
      else $error("verify flag not cleared at programming start");
   group_count_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      state_ff == S_CHECK && code_ff == CMD_ERASE_GROUP && !tgt_locked
      |=> o_array_start && o_array_req.count ==
          (GROUP_BASE << $past(arg_ff[1:0])))
      else $error("erase group count wrong");
   status_clear_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      rd_status && !bad_cmd && !lock_err_set && i_ecc == '0
      |=> !cmd_err_ff && !lock_err_ff && ecc_flags == '0)
      else $error("status read did not clear flags");
   ecc_sticky_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      i_ecc.single_lo ##1 !rd_status |=> ecc_flags.single_lo)
      else $error("single ecc flag lost before status read");
   lock_prog_a: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      state_ff == S_WAIT && i_array_done && code_ff == CMD_PROG_LOCK
      |=> lock_bits[region_of($past(arg_ff))])
      else $error("program and lock left region unlocked");

endmodule

// >>> dv/flash_command_and_status_bench.sv
// Self-checking bench for the flash command and status core.
// Assumes the bench stands in for software on the register port and for
// the flash array on the start and done handshake.
`timescale 1ns/100ps
module flash_command_and_status_bench;
   import fcs_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_array_done = 1'b0;
   logic i_array_verify_fail = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic [31:0] o_rdata;
   fcs_ecc_evt_t i_ecc = 4'h0;
   fcs_array_req_t o_array_req;
   logic o_irq, o_array_start, o_id_mode, o_sig_mode;
   logic [7:0] o_boot_bits;
   logic [3:0] o_wait_states;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int vf = 0;
   // Bench model of the region lock bits, one bit per 128-page region.
   logic [63:0] locks_m = '0;
   logic [31:0] rs = 32'he4e04100;
   logic [7:0] codes [8] = '{8'h05, 8'h01, 8'h03, 8'h11, 8'h12, 8'h13,
      8'h02, 8'h04};

   fcs_core DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_irq(o_irq), .o_array_req(o_array_req),
      .o_array_start(o_array_start), .i_array_done(i_array_done),
      .i_array_verify_fail(i_array_verify_fail), .i_ecc(i_ecc),
      .o_id_mode(o_id_mode), .o_sig_mode(o_sig_mode),
      .o_boot_bits(o_boot_bits), .o_wait_states(o_wait_states));

   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   function logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task stop_test;
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask

   // Issues one command word, plays the array side if an operation starts,
   // then checks the status word against the bench's own flag model.
   task run(input logic [7:0] c, input logic [15:0] arg,
      input logic [7:0] key, input bit st, input bit lk);
      bit seen;
      logic [31:0] exp;
      seen = 1'b0;
      wr(ADDR_CMD, {key, arg, c});
      for (int i = 0; i < 6; i++) begin
         @(posedge i_core_clk);
         #1;
         if (o_array_start === 1'b1)
            seen = 1'b1;
      end
      chk(seen, st);
      if (seen) begin
         chk(o_array_req.code, c);
         if (c < 8'h05)
            chk(o_array_req.page, arg);
         vf = 0;
         rd(ADDR_STATUS, 32'h0);
         chk(o_irq, 1'b0);
         vf = rnd() & 1;
         @(posedge i_core_clk);
         i_array_done <= 1'b1;
         i_array_verify_fail <= vf[0];
         @(posedge i_core_clk);
         i_array_done <= 1'b0;
         i_array_verify_fail <= 1'b0;
      end
      // Program-and-lock forms lock their region once the array is done.
      if (key == KEY_VALUE && c == 8'h09)
         locks_m[arg[12:7]] = 1'b0;
      if (key == KEY_VALUE && (c == 8'h08 ||
         (seen && (c == 8'h02 || c == 8'h04))))
         locks_m[arg[12:7]] = 1'b1;
      repeat (3) @(posedge i_core_clk);
      #1;
      chk(o_irq, 1'b1);
      exp = 32'h1 | (vf << 3);
      exp[2] = lk;
      exp[1] = (key !== KEY_VALUE) || c == 8'h06 || c > 8'h15;
      rd(ADDR_STATUS, exp);
   endtask

   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         stop_test;
      end
   end

   initial begin
      logic [15:0] p;
      logic [3:0] e;
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      rd(ADDR_STATUS, 32'h1);
      rd(ADDR_MODE, MODE_RESET);
      chk(o_irq, 1'b0);
      wr(ADDR_MODE, 32'hffff_ffff);
      rd(ADDR_MODE, MODE_WMASK);
      chk(o_wait_states, 4'hf);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0);
      rd(ADDR_CMD, 32'h0);
      run(8'h01, 16'h0, 8'ha5, 0, 0);
      run(8'h06, 16'h0, KEY_VALUE, 0, 0);
      run(8'h16, 16'h0, KEY_VALUE, 0, 0);
      // Descriptor words are the core's default parameter values.
      run(8'h00, 16'h0, KEY_VALUE, 0, 0);
      rd(ADDR_RESULT, 32'h0000_0a5c);
      rd(ADDR_RESULT, 32'h0010_0000);
      rd(ADDR_RESULT, 32'h0000_0200);
      rd(ADDR_RESULT, 32'd64);
      rd(ADDR_RESULT, 32'h0);
      run(8'h10, 16'h0, KEY_VALUE, 0, 0);
      rd(ADDR_RESULT, 32'h0);
      for (int i = 0; i < 8; i++) begin
         p = 16'((i + 1) * 128) | 16'(rnd() & 32'h7f);
         run(codes[i], (codes[i] == 8'h05 || codes[i] == 8'h12 ||
            codes[i] == 8'h13) ? 16'h0 : p, KEY_VALUE, 1, 0);
      end
      run(8'h0a, 16'h0, KEY_VALUE, 0, 0);
      rd(ADDR_RESULT, locks_m[31:0]);
      rd(ADDR_RESULT, locks_m[63:32]);
      run(8'h01, 16'd901, KEY_VALUE, 0, 1);
      run(8'h09, 16'd896, KEY_VALUE, 0, 0);
      run(8'h01, 16'd901, KEY_VALUE, 1, 0);
      run(8'h08, 16'd4000, KEY_VALUE, 0, 0);
      run(8'h03, 16'd3990, KEY_VALUE, 0, 1);
      run(8'h0a, 16'h0, KEY_VALUE, 0, 0);
      rd(ADDR_RESULT, locks_m[31:0]);
      for (int k = 0; k < 4; k++) begin
         p = 16'h1000 | 16'(rnd() & 32'h0fe0);
         run(8'h07, p | 16'(k), KEY_VALUE, 1, 0);
         chk(o_array_req.page, p);
         chk(o_array_req.count, 32'd4 << k);
      end
      run(8'h0b, 16'h3, KEY_VALUE, 0, 0);
      chk(o_boot_bits, 8'h08);
      run(8'h0d, 16'h0, KEY_VALUE, 0, 0);
      rd(ADDR_RESULT, 32'h8);
      run(8'h0c, 16'h3, KEY_VALUE, 0, 0);
      chk(o_boot_bits, 8'h00);
      run(8'h0e, 16'h0, KEY_VALUE, 0, 0);
      chk(o_id_mode, 1'b1);
      run(8'h0f, 16'h0, KEY_VALUE, 0, 0);
      chk(o_id_mode, 1'b0);
      run(8'h14, 16'h0, KEY_VALUE, 0, 0);
      chk(o_sig_mode, 1'b1);
      run(8'h15, 16'h0, KEY_VALUE, 0, 0);
      chk(o_sig_mode, 1'b0);
      for (int j = 0; j < 4; j++) begin
         e = 4'(rnd());
         @(posedge i_core_clk);
         i_ecc <= e;
         @(posedge i_core_clk);
         i_ecc <= 4'h0;
         rd(ADDR_STATUS, 32'h1 | (vf << 3) | (e << 16));
         rd(ADDR_STATUS, 32'h1 | (vf << 3));
      end
      stop_test;
   end
endmodule
